// file: rtl/bcr_baud_restart.sv
`timescale 1ns/1ps
module bcr_baud_restart #(
    parameter int RELOAD_WIDTH = bcr_pkg::RELOAD_WIDTH,
    parameter int BIT_COUNT = 8
) (
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    input wire logic I2C_MODE_IN,
    input wire logic [RELOAD_WIDTH-1:0] BAUD_RELOAD_VALUE_IN,
    input wire logic SERIAL_TX_BUFFER_WRITE_IN,
    input wire logic RESTART_REQUEST_IN,
    input wire logic COLLISION_CLEAR_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SCL_OUT,
    output logic SCL_OE_OUT,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    output logic SPI_CLOCK_OUT,
    output logic RELOAD_STROBE_OUT,
    output logic BUSY_OUT,
    output logic RESTART_DONE_OUT,
    output logic COLLISION_OUT
);
    localparam int EDGE_WIDTH = $clog2(2 * BIT_COUNT + 1);
    localparam logic [EDGE_WIDTH-1:0] LAST_EDGE = EDGE_WIDTH'(2 * BIT_COUNT - 1);

    bcr_pkg::bcr_state_type state_q, state_d;
    logic busy_q, busy_d;
    logic [RELOAD_WIDTH-1:0] count_q, count_d;
    logic prescale_q, prescale_d;
    logic reload_q, reload_d;
    logic scl_low_q, scl_low_d;
    logic sda_low_q, sda_low_d;
    logic spi_clk_q, spi_clk_d;
    logic done_q, done_d;
    logic coll_q, coll_d;
    logic [EDGE_WIDTH-1:0] edges_q, edges_d;
    logic scl_prev_q, scl_prev_d;
    logic timeout;
    logic scl_fell;
    logic start_restart;
    logic start_xfer;
    logic xfer_toggle;
    logic xfer_last;
    logic release_scl;
    logic scl_seen_high;
    logic drive_sda;
    logic sda_held_reload;
    logic finish_restart;
    logic collision_event;
    logic load_counter;

    // One count step every two oscillator clocks gives Fosc/(4*(reload+1)).
    assign timeout = (count_q == '0) && prescale_q;
    assign scl_fell = scl_prev_q && !SCL_IN;
    assign load_counter = start_restart || start_xfer || (xfer_toggle && !xfer_last)
        || scl_seen_high || drive_sda || sda_held_reload;

    always_comb begin
        start_restart = 1'b0;
        start_xfer = 1'b0;
        xfer_toggle = 1'b0;
        xfer_last = 1'b0;
        release_scl = 1'b0;
        scl_seen_high = 1'b0;
        drive_sda = 1'b0;
        sda_held_reload = 1'b0;
        finish_restart = 1'b0;
        collision_event = 1'b0;
        case (state_q)
            bcr_pkg::ST_IDLE: begin
                if (RESTART_REQUEST_IN && I2C_MODE_IN) begin
                    start_restart = 1'b1;
                end else if (SERIAL_TX_BUFFER_WRITE_IN) begin
                    start_xfer = 1'b1;
                end
            end
            bcr_pkg::ST_XFER: begin
                if (timeout) begin
                    xfer_toggle = 1'b1;
                    xfer_last = (edges_q == LAST_EDGE);
                end
            end
            bcr_pkg::ST_RS_SDA_RELEASE: begin
                release_scl = timeout;
            end
            bcr_pkg::ST_RS_SCL_RELEASE: begin
                if (SCL_IN) begin
                    if (!SDA_IN) begin
                        collision_event = 1'b1;
                    end else begin
                        scl_seen_high = 1'b1;
                    end
                end
            end
            bcr_pkg::ST_RS_SCL_HIGH: begin
                if (scl_fell) begin
                    collision_event = 1'b1;
                end else if (timeout && SCL_IN && SDA_IN) begin
                    drive_sda = 1'b1;
                end else if (timeout) begin
                    // Another master holds SDA low; reload the count and check SDA again after another high phase.
                    sda_held_reload = 1'b1;
                end
            end
            bcr_pkg::ST_RS_SDA_LOW: begin
                finish_restart = timeout;
            end
            default: begin
                collision_event = 1'b0;
            end
        endcase
    end

    always_comb begin
        count_d = count_q;
        prescale_d = 1'b0;
        reload_d = 1'b0;
        if (load_counter) begin
            count_d = BAUD_RELOAD_VALUE_IN;
            prescale_d = 1'b0;
            reload_d = 1'b1;
        end else if (state_q != bcr_pkg::ST_IDLE) begin
            prescale_d = !prescale_q;
            if (prescale_q && count_q != '0) begin
                count_d = count_q - 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            count_q <= '0;
            prescale_q <= 1'b0;
            reload_q <= 1'b0;
        end else begin
            count_q <= count_d;
            prescale_q <= prescale_d;
            reload_q <= reload_d;
        end
    end

    always_comb begin
        scl_low_d = scl_low_q;
        sda_low_d = sda_low_q;
        spi_clk_d = spi_clk_q;
        if (start_restart) begin
            sda_low_d = 1'b0;
        end
        if (release_scl) begin
            scl_low_d = 1'b0;
        end
        if (drive_sda) begin
            sda_low_d = 1'b1;
        end
        if (finish_restart) begin
            scl_low_d = 1'b1;
        end
        if (xfer_toggle) begin
            if (I2C_MODE_IN) begin
                scl_low_d = !scl_low_q;
            end else begin
                spi_clk_d = !spi_clk_q;
            end
        end
        if (collision_event) begin
            scl_low_d = 1'b0;
            sda_low_d = 1'b0;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            spi_clk_q <= 1'b0;
        end else begin
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
            spi_clk_q <= spi_clk_d;
        end
    end

    always_comb begin
        state_d = state_q;
        edges_d = edges_q;
        case (state_q)
            bcr_pkg::ST_IDLE: begin
                if (start_restart) begin
                    state_d = bcr_pkg::ST_RS_SDA_RELEASE;
                end else if (start_xfer) begin
                    state_d = bcr_pkg::ST_XFER;
                    edges_d = '0;
                end
            end
            bcr_pkg::ST_XFER: begin
                if (xfer_toggle) begin
                    edges_d = edges_q + 1'b1;
                    if (xfer_last) begin
                        state_d = bcr_pkg::ST_IDLE;
                    end
                end
            end
            bcr_pkg::ST_RS_SDA_RELEASE: begin
                if (release_scl) begin
                    state_d = bcr_pkg::ST_RS_SCL_RELEASE;
                end
            end
            bcr_pkg::ST_RS_SCL_RELEASE: begin
                if (scl_seen_high) begin
                    state_d = bcr_pkg::ST_RS_SCL_HIGH;
                end
            end
            bcr_pkg::ST_RS_SCL_HIGH: begin
                if (drive_sda) begin
                    state_d = bcr_pkg::ST_RS_SDA_LOW;
                end
            end
            bcr_pkg::ST_RS_SDA_LOW: begin
                if (finish_restart) begin
                    state_d = bcr_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = bcr_pkg::ST_IDLE;
            end
        endcase
        if (collision_event) begin
            state_d = bcr_pkg::ST_IDLE;
        end
        busy_d = (state_d != bcr_pkg::ST_IDLE);
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            state_q <= bcr_pkg::ST_IDLE;
            busy_q <= 1'b0;
            edges_q <= '0;
        end else begin
            state_q <= state_d;
            busy_q <= busy_d;
            edges_q <= edges_d;
        end
    end

    always_comb begin
        done_d = finish_restart;
        coll_d = coll_q;
        scl_prev_d = SCL_IN;
        if (COLLISION_CLEAR_IN) begin
            coll_d = 1'b0;
        end
        // A new collision beats a clear.
        if (collision_event) begin
            coll_d = 1'b1;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            done_q <= 1'b0;
            coll_q <= 1'b0;
            scl_prev_q <= 1'b1;
        end else begin
            done_q <= done_d;
            coll_q <= coll_d;
            scl_prev_q <= scl_prev_d;
        end
    end

    // Open-drain pins: only ever drive low.
    assign SCL_OUT = 1'b0;
    assign SDA_OUT = 1'b0;
    assign SCL_OE_OUT = scl_low_q;
    assign SDA_OE_OUT = sda_low_q;
    assign SPI_CLOCK_OUT = spi_clk_q;
    assign RELOAD_STROBE_OUT = reload_q;
    assign BUSY_OUT = busy_q;
    assign RESTART_DONE_OUT = done_q;
    assign COLLISION_OUT = coll_q;
endmodule : bcr_baud_restart

// file: rtl/bcr_pkg.sv
package bcr_pkg;
    localparam int RELOAD_WIDTH = 8;
    localparam logic [7:0] RELOAD_MIN_I2C = 8'h03;
    localparam logic [7:0] RELOAD_RESET = 8'h09;
    localparam int PHASES_PER_PERIOD = 2;
    localparam int OSC_PER_COUNT = 2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RS_SDA_RELEASE = 3'b001,
        ST_RS_SCL_RELEASE = 3'b010,
        ST_RS_SCL_HIGH = 3'b011,
        ST_RS_SDA_LOW = 3'b100,
        ST_XFER = 3'b101
    } bcr_state_type;
endpackage : bcr_pkg

// file: testbench/bcr_monitor.sv
`timescale 1ns/1ps
module bcr_monitor (
    input logic CLOCK_IN,
    input logic RESET_IN,
    input logic I2C_MODE_IN,
    input logic RESTART_REQUEST_IN,
    input logic COLLISION_CLEAR_IN,
    input logic SCL_OUT,
    input logic SCL_OE_OUT,
    input logic SDA_OUT,
    input logic SDA_OE_OUT,
    input logic RELOAD_STROBE_OUT,
    input logic BUSY_OUT,
    input logic RESTART_DONE_OUT,
    input logic COLLISION_OUT
);
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (RESET_IN);
    a_lines_open: assert property (!SCL_OUT && !SDA_OUT)
        else $error("pin level not low");
    a_restart_load: assert property (RESTART_REQUEST_IN && I2C_MODE_IN && !BUSY_OUT
        |=> BUSY_OUT && RELOAD_STROBE_OUT) else $error("restart not loaded");
    a_done_ends: assert property (RESTART_DONE_OUT
        |-> SCL_OE_OUT && SDA_OE_OUT ##1 !RESTART_DONE_OUT) else $error("bad done");
    a_strobe_pulse: assert property (RELOAD_STROBE_OUT |=> !RELOAD_STROBE_OUT)
        else $error("strobe too long");
    a_flag_sticky: assert property (COLLISION_OUT && !COLLISION_CLEAR_IN |=> COLLISION_OUT)
        else $error("flag lost");
    a_flag_clear: assert property ($fell(COLLISION_OUT) |-> $past(COLLISION_CLEAR_IN))
        else $error("flag fell alone");
    a_collision_free: assert property ($rose(COLLISION_OUT)
        |-> ##[0:2] (!SCL_OE_OUT && !SDA_OE_OUT && !BUSY_OUT)) else $error("lines held");
    a_done_idle: assert property (RESTART_DONE_OUT |-> ##[0:1] !BUSY_OUT)
        else $error("busy after done");
endmodule : bcr_monitor
bind bcr_baud_restart bcr_monitor u_mon (.*);

// file: testbench/bcr_bus_model.sv
`timescale 1ns/1ps
module bcr_bus_model (
    input wire logic scl_oe_in,
    input wire logic sda_oe_in,
    input wire logic hold_scl_in,
    input wire logic hold_sda_in,
    output logic scl_out,
    output logic sda_out
);
    // Pull-ups hold each line high unless some party pulls it low.
    assign scl_out = !(scl_oe_in || hold_scl_in);
    assign sda_out = !(sda_oe_in || hold_sda_in);
endmodule : bcr_bus_model

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, mode = 1'b1, wr = 1'b0, rs = 1'b0, clr = 1'b0;
    logic hs = 1'b0, hd = 1'b0, scl, sda, so, do_, spi, stb, busy, done, col;
    logic [7:0] rld = bcr_pkg::RELOAD_MIN_I2C;
    int err_total = 0, tests_run = 0, cyc = 0;
    always #2.5 clk = ~clk;
    bcr_bus_model u_bus (.scl_oe_in(so), .sda_oe_in(do_), .hold_scl_in(hs),
        .hold_sda_in(hd), .scl_out(scl), .sda_out(sda));
    bcr_baud_restart u_dut (.CLOCK_IN(clk), .RESET_IN(rst), .I2C_MODE_IN(mode),
        .BAUD_RELOAD_VALUE_IN(rld), .SERIAL_TX_BUFFER_WRITE_IN(wr), .RESTART_REQUEST_IN(rs),
        .COLLISION_CLEAR_IN(clr), .SCL_IN(scl), .SDA_IN(sda), .SCL_OUT(), .SCL_OE_OUT(so),
        .SDA_OUT(), .SDA_OE_OUT(do_), .SPI_CLOCK_OUT(spi), .RELOAD_STROBE_OUT(stb),
        .BUSY_OUT(busy), .RESTART_DONE_OUT(done), .COLLISION_OUT(col));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            stop_test();
        end
    end
    // Kind 0 clean, 1 data held low, 2 clock pulled low early, 3 data blip in high phase.
    task automatic restart(input int kind);
        int n = 0, k = 0, m = 0, t = 0;
        @(posedge clk);
        rs <= 1'b1;
        hd <= (kind == 1);
        @(posedge clk);
        rs <= 1'b0;
        while (!done && !col && n < 200) begin
            @(posedge clk);
            n++;
            k += stb;
            m += (k >= 2);
            if (do_ && t == 0) t = n;
            if (kind == 2) hs <= (m >= 2);
            if (kind == 3) hd <= (m == 2 || m == 3);
        end
        if (kind == 1 || kind == 2) begin
            check("collision", col, 1'b1);
            repeat (3) @(posedge clk);
            check("lines", {so, do_, busy}, 3'b000);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            repeat (2) @(posedge clk);
            check("cleared", col, 1'b0);
        end else begin
            check("done", {done, col}, 2'b10);
            check("strobes", 8'(k), 8'h03);
            check("sda to scl", 8'(n - t), 8'(2 * (rld + 1)));
        end
        hs <= 1'b0;
        hd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : restart
    task automatic spi_xfer();
        int n = 0, tog = 0, last = 0;
        logic prev;
        mode <= 1'b0;
        rld <= 8'h00;
        @(posedge clk);
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        prev = spi;
        while (busy && n < 500) begin
            @(posedge clk);
            n++;
            if (spi !== prev && tog > 0) check("spi gap", 8'(n - last), 8'h02);
            if (spi !== prev) begin
                tog++;
                last = n;
            end
            prev = spi;
        end
        repeat (5) @(posedge clk);
        check("toggles", 8'(tog), 8'h10);
        check("held", spi, prev);
        mode <= 1'b1;
        rld <= bcr_pkg::RELOAD_MIN_I2C;
    endtask : spi_xfer
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // Reload kept at 3 or more in two-wire mode.
        for (int i = 0; i < 4; i++) restart(i);
        spi_xfer();
        stop_test();
    end
endmodule : testbench
